// ---- arllr_core.sv ----
// label filter, loopback transmitter, fifos and resets for eight receive channels
`timescale 1ns/1ps
// Operation
// - with filtering on, words whose label misses the table are dropped; word_complete_strobe still pulses.
// - label zero compares like any other label value.
// - table compare ignores bit-reverse; loaded byte msb is label msb.
// - filter enable clear means every label is accepted.
// - label table entries of a selected channel are returned on request.
// - loopback per channel, active when loopback_select_n is zero.
// - host loads 32-bit test word with high or low speed; device sends at it.
// - after load the word is shifted out and offered to all eight channels.
// - loopback channel with matching speed treats test word like a bus word.
// - channel without loopback ignores test word and keeps its external input.
// - test word always drives tx outputs: null both low, one/zero on own pin.
// - first bit shifted in, the word lsb, is the first bit sent.
// - master reset aborts reception, empties all fifos and clears their flags.
// - master reset leaves control registers and label tables untouched.
// - master reset comes from the reset pin or the reset command.
// - any control register write clears that channel's label table.
// - channel reset bit set clears and disables the channel until cleared.
// - word stored only if it passes label and enabled bit 10/9 matching.
// - four-word fifo; when full a new word overwrites the newest one.
// - stored words are returned on the per-channel fifo read request.
// - bit 32 is replaced by parity flag, 0 for odd and 1 for even.
module arllr_core (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ref_1mhz_in,
  input wire logic master_reset_pin,
  input wire logic master_reset_cmd,
  input wire logic ctrl_wr,
  input wire arllr_pkg::arllr_ch_t ctrl_ch,
  input wire arllr_pkg::arllr_byte_t ctrl_wdata,
  input wire logic label_wr,
  input wire logic label_rd,
  input wire arllr_pkg::arllr_ch_t label_ch,
  input wire arllr_pkg::arllr_lidx_t label_idx,
  input wire arllr_pkg::arllr_byte_t label_byte,
  output arllr_pkg::arllr_byte_t label_rdata,
  output logic label_rvalid,
  input wire logic fifo_rd,
  input wire arllr_pkg::arllr_ch_t fifo_ch,
  output arllr_pkg::arllr_word_t fifo_rdata,
  output logic fifo_rvalid,
  input wire logic tx_load,
  input wire logic tx_low_speed,
  input wire arllr_pkg::arllr_word_t tx_word,
  output logic tx_busy,
  output logic tx_one_out,
  output logic tx_zero_out,
  input wire logic [arllr_pkg::NCH-1:0] ext_word_valid,
  input wire logic [arllr_pkg::NCH*arllr_pkg::WBITS-1:0] ext_word,
  output logic [arllr_pkg::NCH-1:0] word_complete_strobe,
  output logic [arllr_pkg::NCH-1:0] fifo_empty,
  output logic [arllr_pkg::NCH-1:0] fifo_full
);
  import arllr_pkg::*;

  // synchronisers for the reference clock and reset pin
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_s3_r;
  logic mrp_s1_r;
  logic mrp_s2_r;
  wire ref_tick = ref_s2_r & ~ref_s3_r;
  wire mr_all = mrp_s2_r | master_reset_cmd;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      mrp_s1_r <= 1'b0;
      mrp_s2_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_1mhz_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      mrp_s1_r <= master_reset_pin;
      mrp_s2_r <= mrp_s1_r;
    end
  end

  // transmit register
  arllr_tx_e tx_state_r;
  arllr_word_t tx_shift_r;
  logic tx_low_r;
  arllr_tick_t tick_cnt_r;
  arllr_bit_t bit_cnt_r;
  arllr_word_t loop_shift_r;
  logic loop_armed_r;
  logic loop_valid_r;
  logic tx_one_r;
  logic tx_zero_r;

  wire arllr_tick_t bit_ticks = tx_low_r ? LS_BIT_TICKS : HS_BIT_TICKS;
  wire arllr_tick_t half_ticks = tx_low_r ? LS_HALF_TICKS : HS_HALF_TICKS;
  wire bit_end = ref_tick && (tick_cnt_r == bit_ticks - 7'h01);
  wire in_bit = tx_state_r == TX_BIT;
  wire high_half = in_bit && (tick_cnt_r < half_ticks);
  wire word_end = in_bit && bit_end && (bit_cnt_r == LAST_BIT);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= '0;
      tx_low_r <= 1'b0;
      tick_cnt_r <= '0;
      bit_cnt_r <= '0;
    end else if (tx_load) begin
      tx_state_r <= TX_BIT;
      tx_shift_r <= tx_word;
      tx_low_r <= tx_low_speed;
      tick_cnt_r <= '0;
      bit_cnt_r <= '0;
    end else if (ref_tick && tx_state_r != TX_IDLE) begin
      if (bit_end) begin
        tick_cnt_r <= '0;
        case (tx_state_r)
          TX_BIT: begin
            tx_shift_r <= {1'b0, tx_shift_r[WBITS-1:1]};
            bit_cnt_r <= (bit_cnt_r == LAST_BIT) ? 5'h00 : bit_cnt_r + 5'h01;
            if (bit_cnt_r == LAST_BIT) begin
              tx_state_r <= TX_GAP;
            end
          end
          TX_GAP: begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == GAP_LAST_BIT) begin
              tx_state_r <= TX_IDLE;
            end
          end
          default: tx_state_r <= TX_IDLE;
        endcase
      end else begin
        tick_cnt_r <= tick_cnt_r + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_one_r <= 1'b0;
      tx_zero_r <= 1'b0;
    end else begin
      tx_one_r <= high_half && tx_shift_r[0];
      tx_zero_r <= high_half && !tx_shift_r[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      loop_shift_r <= '0;
      loop_armed_r <= 1'b0;
      loop_valid_r <= 1'b0;
    end else begin
      if (in_bit && ref_tick && tick_cnt_r == 7'h00) begin
        loop_shift_r <= {tx_shift_r[0], loop_shift_r[WBITS-1:1]};
      end
      if (tx_load) begin
        loop_armed_r <= 1'b1;
      end else if (mr_all || word_end) begin
        loop_armed_r <= 1'b0;
      end
      loop_valid_r <= word_end && loop_armed_r && !mr_all && !tx_load;
    end
  end

  assign tx_busy = tx_state_r != TX_IDLE;
  assign tx_one_out = tx_one_r;
  assign tx_zero_out = tx_zero_r;

  // per-channel logic
  logic [NCH*WBITS-1:0] mem_rd_w;
  logic [NCH*8-1:0] lbl_rd_w;

  genvar ch;
  genvar e;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      logic [7:0] ctrl_r;
      arllr_byte_t lbl_r [NLBL];
      logic [NLBL-1:0] lbl_v_r;
      logic [NLBL-1:0] lbl_hit;
      arllr_ptr_t wptr_r;
      arllr_ptr_t rptr_r;
      arllr_cnt_t cnt_r;

      wire sel_ctrl = ctrl_wr && (ctrl_ch == arllr_ch_t'(ch));
      wire sel_lbl = label_wr && (label_ch == arllr_ch_t'(ch));
      wire loop_on = !ctrl_r[CF_LOOP_N];
      wire enabled = !ctrl_r[CF_CHAN_RESET];
      wire speed_ok = ctrl_r[CF_LOW_SPEED] == tx_low_r;
      wire in_valid = loop_on ? (loop_valid_r && speed_ok) : ext_word_valid[ch];
      wire arllr_word_t in_word = loop_on ? loop_shift_r : ext_word[ch*WBITS +: WBITS];
      wire arllr_byte_t in_label = in_word[WF_LABEL_MSB:WF_LABEL_LSB];

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          ctrl_r <= CTRL_RESET_VAL;
        end else if (sel_ctrl) begin
          ctrl_r <= ctrl_wdata;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst || sel_ctrl) begin
          lbl_v_r <= '0;
        end else if (sel_lbl) begin
          lbl_v_r[label_idx] <= 1'b1;
        end
      end

      // stored byte msb is label msb
      always_ff @(posedge ref_clk) begin
        if (sel_lbl) begin
          lbl_r[label_idx] <= label_byte;
        end
      end

      for (e = 0; e < NLBL; e = e + 1) begin : g_lbl
        assign lbl_hit[e] = lbl_v_r[e] && (lbl_r[e] == in_label);
      end

      assign lbl_rd_w[ch*8 +: 8] = lbl_v_r[label_idx] ? lbl_r[label_idx] : 8'h00;

      wire label_ok = !ctrl_r[CF_LABEL_FILTER] || (|lbl_hit);
      wire pair_ok = !ctrl_r[CF_PAIR_EN] ||
                     ((in_word[WF_BIT10] == ctrl_r[CF_MATCH10]) && (in_word[WF_BIT9] == ctrl_r[CF_MATCH9]));
      wire got_word = in_valid && enabled && !mr_all && !sel_ctrl;
      wire accept = got_word && label_ok && pair_ok;
      assign word_complete_strobe[ch] = got_word;

      wire arllr_byte_t rev_label = {<<{in_label}};
      wire arllr_byte_t out_label = ctrl_r[CF_LABEL_REV] ? rev_label : in_label;
      wire arllr_word_t store_word = {~(^in_word), in_word[WF_PARITY-1:WF_LABEL_MSB+1], out_label};

      wire full = cnt_r == FIFO_FULL_CNT;
      wire rd = fifo_rd && (fifo_ch == arllr_ch_t'(ch)) && (cnt_r != 3'h0);
      wire overwrite = full && !rd;
      wire inc = accept && !overwrite;
      wire arllr_ptr_t wr_addr = overwrite ? wptr_r - 2'h1 : wptr_r;
      wire grow = inc && !rd;
      wire shrink = rd && !inc;
      wire arllr_cnt_t cnt_nxt = grow ? cnt_r + 3'h1 : (shrink ? cnt_r - 3'h1 : cnt_r);
      wire clr = mr_all || !enabled || sel_ctrl;

      always_ff @(posedge ref_clk) begin
        if (!nrst || clr) begin
          wptr_r <= '0;
          rptr_r <= '0;
          cnt_r <= '0;
        end else begin
          if (inc) begin
            wptr_r <= wptr_r + 2'h1;
          end
          if (rd) begin
            rptr_r <= rptr_r + 2'h1;
          end
          cnt_r <= cnt_nxt;
        end
      end

      arllr_fifo_mem u_mem (
        .ref_clk(ref_clk),
        .wr_en(accept),
        .wr_addr(wr_addr),
        .wr_data(store_word),
        .rd_en(rd),
        .rd_addr(rptr_r),
        .rd_data(mem_rd_w[ch*WBITS +: WBITS])
      );

      assign fifo_empty[ch] = cnt_r == 3'h0;
      assign fifo_full[ch] = full;
    end
  endgenerate

  // read return path
  arllr_ch_t rd_ch_r;
  logic rd_pend_r;
  arllr_word_t fifo_rdata_r;
  logic fifo_rvalid_r;
  arllr_byte_t label_rdata_r;
  logic label_rvalid_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_ch_r <= '0;
      rd_pend_r <= 1'b0;
      fifo_rdata_r <= '0;
      fifo_rvalid_r <= 1'b0;
      label_rdata_r <= '0;
      label_rvalid_r <= 1'b0;
    end else begin
      rd_pend_r <= fifo_rd;
      if (fifo_rd) begin
        rd_ch_r <= fifo_ch;
      end
      fifo_rvalid_r <= rd_pend_r;
      if (rd_pend_r) begin
        fifo_rdata_r <= mem_rd_w[rd_ch_r*WBITS +: WBITS];
      end
      label_rvalid_r <= label_rd;
      if (label_rd) begin
        label_rdata_r <= lbl_rd_w[label_ch*8 +: 8];
      end
    end
  end

  assign fifo_rdata = fifo_rdata_r;
  assign fifo_rvalid = fifo_rvalid_r;
  assign label_rdata = label_rdata_r;
  assign label_rvalid = label_rvalid_r;
endmodule // arllr_core

// ---- arllr_pkg.sv ----
// shared constants and types for the receiver label, loopback and reset block
package arllr_pkg;
  localparam int NCH = 8;
  localparam int WBITS = 32;
  localparam int FDEPTH = 4;
  localparam int FAW = 2;
  localparam int NLBL = 16;
  localparam int LAW = 4;
  typedef logic [2:0] arllr_ch_t;
  typedef logic [31:0] arllr_word_t;
  typedef logic [7:0] arllr_byte_t;
  typedef logic [3:0] arllr_lidx_t;
  typedef logic [FAW-1:0] arllr_ptr_t;
  typedef logic [2:0] arllr_cnt_t;
  typedef logic [6:0] arllr_tick_t;
  typedef logic [4:0] arllr_bit_t;
  // control register field positions
  localparam int CF_LOW_SPEED = 0;
  localparam int CF_LABEL_FILTER = 1;
  localparam int CF_CHAN_RESET = 2;
  localparam int CF_LOOP_N = 3;
  localparam int CF_PAIR_EN = 4;
  localparam int CF_MATCH10 = 5;
  localparam int CF_MATCH9 = 6;
  localparam int CF_LABEL_REV = 7;
  // word field positions
  localparam int WF_LABEL_LSB = 0;
  localparam int WF_LABEL_MSB = 7;
  localparam int WF_BIT9 = 8;
  localparam int WF_BIT10 = 9;
  localparam int WF_PARITY = 31;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
  localparam arllr_cnt_t FIFO_FULL_CNT = 3'h4;
  localparam arllr_bit_t LAST_BIT = 5'h1f;
  localparam arllr_bit_t GAP_LAST_BIT = 5'h03;
  // bit timing in 1 us reference ticks: one half high, one half null
  localparam arllr_tick_t HS_BIT_TICKS = 7'h0a;
  localparam arllr_tick_t HS_HALF_TICKS = 7'h05;
  localparam arllr_tick_t LS_BIT_TICKS = 7'h50;
  localparam arllr_tick_t LS_HALF_TICKS = 7'h28;
  typedef enum logic [1:0] {TX_IDLE, TX_BIT, TX_GAP} arllr_tx_e;
endpackage

// ---- arllr_fifo_mem.sv ----
// four-word receive fifo storage with registered read data
`timescale 1ns/1ps
module arllr_fifo_mem (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire arllr_pkg::arllr_ptr_t wr_addr,
  input wire arllr_pkg::arllr_word_t wr_data,
  input wire logic rd_en,
  input wire arllr_pkg::arllr_ptr_t rd_addr,
  output arllr_pkg::arllr_word_t rd_data
);
  import arllr_pkg::*;
  arllr_word_t mem_r [FDEPTH];
  arllr_word_t rd_data_r;

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule // arllr_fifo_mem

// ---- arllr_core_asserts.sv ----
// concurrent checks on the core ports
`timescale 1ns/1ps
module arllr_core_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic master_reset_pin,
  input wire logic master_reset_cmd,
  input wire logic ctrl_wr,
  input wire arllr_pkg::arllr_ch_t ctrl_ch,
  input wire logic label_rd,
  input wire logic label_rvalid,
  input wire logic fifo_rd,
  input wire logic fifo_rvalid,
  input wire logic tx_load,
  input wire logic tx_busy,
  input wire logic tx_one_out,
  input wire logic tx_zero_out,
  input wire logic [arllr_pkg::NCH-1:0] fifo_empty,
  input wire logic [arllr_pkg::NCH-1:0] fifo_full
);
  import arllr_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence pop_s;
    fifo_rd ##2 fifo_rvalid;
  endsequence
  sequence pin_hold_s;
    master_reset_pin [*4];
  endsequence
  tx_null_a: assert property (!(tx_one_out && tx_zero_out))
    else $error("both transmit outputs high");
  tx_idle_a: assert property (!tx_busy |-> !tx_one_out && !tx_zero_out)
    else $error("transmit output active while idle");
  tx_start_a: assert property (tx_load |=> tx_busy)
    else $error("load did not start transmit");
  flag_excl_a: assert property ((fifo_empty & fifo_full) == 8'h00)
    else $error("fifo empty and full together");
  mr_cmd_a: assert property (master_reset_cmd |=> &fifo_empty)
    else $error("reset command left a fifo filled");
  mr_pin_a: assert property (pin_hold_s |-> &fifo_empty)
    else $error("reset pin left a fifo filled");
  ctrl_clear_a: assert property (ctrl_wr |=> fifo_empty[$past(ctrl_ch)])
    else $error("control write kept fifo words");
  label_ans_a: assert property (label_rd |=> label_rvalid)
    else $error("label read not answered");
  fifo_ans_a: assert property (fifo_rd |-> pop_s)
    else $error("fifo read not answered");
endmodule // arllr_core_asserts
bind arllr_core arllr_core_asserts u_chk (.ref_clk, .nrst, .master_reset_pin, .master_reset_cmd, .ctrl_wr,
  .ctrl_ch, .label_rd, .label_rvalid, .fifo_rd, .fifo_rvalid, .tx_load, .tx_busy, .tx_one_out, .tx_zero_out,
  .fifo_empty, .fifo_full);

// ---- arllr_host_model.sv ----
// host side reference tick source
`timescale 1ns/1ps
module arllr_host_model (
  output logic ref_1mhz_in
);
  initial begin
    ref_1mhz_in = 1'b0;
    #37;
    forever #100 ref_1mhz_in = ~ref_1mhz_in;
  end
endmodule // arllr_host_model

// ---- test_arllr_rx_label_loopback_reset.sv ----
// self-checking bench for the label, loopback and reset core
`timescale 1ns/1ps
module test_arllr_rx_label_loopback_reset;
  import arllr_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ref_1mhz_in;
  logic master_reset_pin = 1'b0;
  logic master_reset_cmd = 1'b0;
  logic ctrl_wr = 1'b0;
  arllr_ch_t ctrl_ch = 3'h0;
  arllr_byte_t ctrl_wdata = 8'h00;
  logic label_wr = 1'b0;
  logic label_rd = 1'b0;
  arllr_ch_t label_ch = 3'h0;
  arllr_lidx_t label_idx = 4'h0;
  arllr_byte_t label_byte = 8'h00;
  arllr_byte_t label_rdata;
  logic label_rvalid;
  logic fifo_rd = 1'b0;
  arllr_ch_t fifo_ch = 3'h0;
  arllr_word_t fifo_rdata;
  logic fifo_rvalid;
  logic tx_load = 1'b0;
  logic tx_low_speed = 1'b0;
  arllr_word_t tx_word = 32'h0;
  logic tx_busy;
  logic tx_one_out;
  logic tx_zero_out;
  logic [NCH-1:0] ext_word_valid = 8'h00;
  logic [NCH*WBITS-1:0] ext_word = 256'h0;
  logic [NCH-1:0] word_complete_strobe;
  logic [NCH-1:0] fifo_empty;
  logic [NCH-1:0] fifo_full;
  int n_errors = 0;
  int n_compared = 0;
  arllr_word_t got;
  arllr_byte_t lb;
  logic stb;
  localparam logic [63:0] CH_CFG = 64'h0401_0800_0838_080a;
  localparam int TICK_CYC = 8;
  arllr_core u_dut (.ref_clk, .nrst, .ref_1mhz_in, .master_reset_pin, .master_reset_cmd, .ctrl_wr, .ctrl_ch,
    .ctrl_wdata, .label_wr, .label_rd, .label_ch, .label_idx, .label_byte, .label_rdata, .label_rvalid, .fifo_rd,
    .fifo_ch, .fifo_rdata, .fifo_rvalid, .tx_load, .tx_low_speed, .tx_word, .tx_busy, .tx_one_out, .tx_zero_out,
    .ext_word_valid, .ext_word, .word_complete_strobe, .fifo_empty, .fifo_full);
  arllr_host_model u_host (.ref_1mhz_in);
  function automatic arllr_word_t expw(input arllr_word_t w);
    return {~^w, w[30:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic ctrl(input arllr_ch_t ch, input arllr_byte_t d);
    @(negedge ref_clk);
    ctrl_ch = ch;
    ctrl_wdata = d;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic lwr(input arllr_ch_t ch, input arllr_lidx_t i, input arllr_byte_t d);
    @(negedge ref_clk);
    label_ch = ch;
    label_idx = i;
    label_byte = d;
    label_wr = 1'b1;
    cyc(1);
    label_wr = 1'b0;
  endtask
  task automatic lrd(input arllr_ch_t ch, input arllr_lidx_t i);
    @(negedge ref_clk);
    label_ch = ch;
    label_idx = i;
    label_rd = 1'b1;
    cyc(1);
    label_rd = 1'b0;
    lb = label_rdata;
    chk("label valid", label_rvalid, 1'b1);
  endtask
  task automatic send(input arllr_ch_t ch, input arllr_word_t w);
    @(negedge ref_clk);
    ext_word[ch*32 +: 32] = w;
    ext_word_valid[ch] = 1'b1;
    #1;
    stb = word_complete_strobe[ch];
    cyc(1);
    ext_word_valid[ch] = 1'b0;
    cyc(1);
  endtask
  task automatic pop(input arllr_ch_t ch, input arllr_word_t exp);
    @(negedge ref_clk);
    fifo_ch = ch;
    fifo_rd = 1'b1;
    cyc(1);
    fifo_rd = 1'b0;
    cyc(1);
    chk("fifo valid", fifo_rvalid, 1'b1);
    chk("fifo word", fifo_rdata, exp);
  endtask
  task automatic t_filter();
    lwr(0, 0, 8'h00);
    lwr(0, 1, 8'h5a);
    send(0, 32'h8000_1200);
    send(0, 32'h0000_035a);
    send(0, 32'h0000_0433);
    pop(0, 32'h0000_1200);
    pop(0, 32'h8000_035a);
    chk("miss dropped", fifo_empty[0], 1'b1);
    lrd(0, 1);
    chk("label entry", lb, 8'h5a);
    send(0, 32'h0000_0300);
    @(negedge ref_clk);
    master_reset_cmd = 1'b1;
    cyc(1);
    master_reset_cmd = 1'b0;
    chk("mr empty", fifo_empty, 8'hff);
    lrd(0, 1);
    chk("label kept", lb, 8'h5a);
    send(0, 32'h0000_0433);
    chk("filter kept", fifo_empty[0], 1'b1);
    ctrl(0, 8'h0a);
    lrd(0, 1);
    chk("label cleared", lb, 8'h00);
    $display("filter test done");
  endtask
  task automatic t_full();
    for (int i = 0; i < 5; i++) send(1, 32'h0000_0010 + i);
    chk("fifo full", fifo_full[1], 1'b1);
    pop(1, expw(32'h10));
    pop(1, expw(32'h11));
    pop(1, expw(32'h12));
    pop(1, expw(32'h14));
    chk("drained", fifo_empty[1], 1'b1);
    $display("fifo test done");
  endtask
  task automatic t_misc();
    send(2, 32'h0000_0101);
    send(2, 32'h0000_0301);
    send(2, 32'h0000_0201);
    pop(2, expw(32'h0201));
    chk("pair drop", fifo_empty[2], 1'b1);
    ctrl(3, 8'h0c);
    send(3, 32'h0000_0077);
    chk("chan reset", fifo_empty[3], 1'b1);
    chk("reset strobe", stb, 1'b0);
    ctrl(3, 8'h08);
    send(3, 32'h0000_0077);
    chk("word strobe", stb, 1'b1);
    pop(3, expw(32'h77));
    send(1, 32'h0000_0055);
    @(negedge ref_clk);
    master_reset_pin = 1'b1;
    cyc(5);
    chk("pin reset", fifo_empty[1], 1'b1);
    master_reset_pin = 1'b0;
    cyc(3);
    $display("misc test done");
  endtask
  task automatic t_loop(input logic ls, input arllr_word_t w, input logic [7:0] exp_e, input logic ser);
    int n;
    int busy_n;
    int per;
    logic prv;
    n = 0;
    busy_n = 0;
    prv = 1'b0;
    got = 32'h0;
    @(negedge ref_clk);
    tx_word = w;
    tx_low_speed = ls;
    tx_load = 1'b1;
    cyc(1);
    tx_load = 1'b0;
    for (int k = 0; k < 30000 && tx_busy === 1'b1; k++) begin
      cyc(1);
      busy_n++;
      if ((tx_one_out | tx_zero_out) && !prv) begin
        got = {tx_one_out, got[31:1]};
        n++;
      end
      prv = tx_one_out | tx_zero_out;
    end
    cyc(3);
    chk("tx done", tx_busy, 1'b0);
    per = (ls ? LS_BIT_TICKS : HS_BIT_TICKS) * TICK_CYC;
    chk("bit times", (busy_n + per / 2) / per, LAST_BIT + GAP_LAST_BIT + 2);
    if (ser) begin
      chk("serial word", got, w);
      chk("bit count", n, 32);
    end
    chk("loop fifos", fifo_empty, exp_e);
    pop(ls ? 3'h6 : 3'h4, expw(w));
    $display("loopback test done");
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #1_500_000;
    n_errors++;
    stop_test();
  end
  initial begin
    cyc(12);
    nrst = 1'b1;
    chk("reset empty", fifo_empty, 8'hff);
    chk("reset tx", {tx_one_out, tx_zero_out}, 2'b00);
    for (int i = 0; i < NCH; i++) ctrl(i[2:0], CH_CFG[8*i +: 8]);
    t_filter();
    t_full();
    t_misc();
    t_loop(1'b0, 32'h8a5c_3e01, 8'hef, 1'b1);
    t_loop(1'b1, 32'h1234_5678, 8'hbf, 1'b1);
    @(negedge ref_clk);
    tx_word = 32'hffff_0000;
    tx_low_speed = 1'b1;
    tx_load = 1'b1;
    cyc(1);
    tx_load = 1'b0;
    cyc(1000);
    t_loop(1'b0, 32'h0f0f_a5a5, 8'hef, 1'b0);
    chk("one word only", fifo_empty, 8'hff);
    stop_test();
  end
endmodule // test_arllr_rx_label_loopback_reset
